// ==== core/bfbx_core.sv ====
// Execution unit for branches on flags, bit ops, shifts and X-pointer loads
`default_nettype none

module bfbx_core #(
  parameter int PC_W     = bfbx_pkg::PC_W,
  parameter int RF_DEPTH = bfbx_pkg::RF_DEPTH
) (
  input  wire logic                          clk_sys,       // System clock
  input  wire logic                          rst_b,         // Synchronous reset, active low
  input  wire logic                          ce,            // Clock enable, freezes all state
  input  wire logic                          op_valid,      // Instruction offered
  output logic                               op_ready,      // Ready to take an instruction this cycle
  input  wire bfbx_pkg::bfbx_op_t            op_code,       // Decoded operation
  input  wire logic [bfbx_pkg::RF_AW-1:0]    op_reg,        // Register operand
  input  wire logic [2:0]                    op_bit,        // Bit or flag select
  input  wire logic [bfbx_pkg::IO_AW-1:0]    op_io,         // I/O address
  input  wire logic [bfbx_pkg::K_W-1:0]      op_k,          // Signed branch offset
  output logic [PC_W-1:0]                    pc,            // Program counter
  output logic [7:0]                         status,        // Status register
  output logic [bfbx_pkg::X_W-1:0]           x_ptr,         // X pointer
  output logic [bfbx_pkg::IO_AW-1:0]         io_addr,       // I/O address
  output logic                               io_rd_en,      // I/O read strobe
  input  wire logic [bfbx_pkg::DATA_W-1:0]   io_rd_data,    // I/O read data, same cycle
  output logic                               io_wr_en,      // I/O write strobe
  output logic [bfbx_pkg::DATA_W-1:0]        io_wr_data,    // I/O write data
  output logic [bfbx_pkg::X_W-1:0]           mem_addr,      // Data memory address
  output logic                               mem_rd_en,     // Data memory read strobe
  input  wire logic [bfbx_pkg::DATA_W-1:0]   mem_rd_data,   // Data memory read data, same cycle
  input  wire logic                          rf_wr_en,      // Preload register write
  input  wire logic [bfbx_pkg::RF_AW-1:0]    rf_wr_addr,    // Preload register address
  input  wire logic [bfbx_pkg::DATA_W-1:0]   rf_wr_data,    // Preload register data
  input  wire logic [bfbx_pkg::RF_AW-1:0]    rf_rd_addr,    // Register observe address
  output logic [bfbx_pkg::DATA_W-1:0]        rf_rd_data,    // Register observe data
  input  wire logic                          x_load_en,     // Preload X pointer
  input  wire logic [bfbx_pkg::X_W-1:0]      x_load_val,    // X preload value
  input  wire logic                          status_register_load_en,  // Preload status register
  input  wire logic [7:0]                    status_register_load_val, // Status preload value
  input  wire logic                          pc_load_en,    // Preload program counter
  input  wire logic [PC_W-1:0]               pc_load_val    // PC preload value
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (PC_W < bfbx_pkg::K_W + 1) begin : g_pc_w_bad
    $error("PC_W too narrow for the branch offset");
  end
  if (RF_DEPTH != (1 << bfbx_pkg::RF_AW)) begin : g_rf_bad
    $error("RF_DEPTH must match the register address width");
  end
  // Flag, shift and pointer logic is written for these widths
  if (bfbx_pkg::DATA_W != 8) begin : g_data_w_bad
    $error("DATA_W must be 8");
  end
  if (bfbx_pkg::X_W != 16) begin : g_x_w_bad
    $error("X_W must be 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  bfbx_pkg::bfbx_state_t               state_q;
  bfbx_pkg::bfbx_state_t               state_d;

  logic [PC_W-1:0]                     pc_q;
  logic [7:0]                          status_register_q;
  logic [bfbx_pkg::X_W-1:0]            x_q;

  logic [bfbx_pkg::DATA_W-1:0]         rf_q [RF_DEPTH];
  logic [bfbx_pkg::DATA_W-1:0]         rf_rd_data_q;

  logic [bfbx_pkg::IO_AW-1:0]          io_addr_q;
  logic                                io_rd_en_q;
  logic                                io_wr_en_q;
  logic [bfbx_pkg::DATA_W-1:0]         io_wr_data_q;
  logic [2:0]                          io_bit_q;
  logic                                io_set_q;

  logic [bfbx_pkg::X_W-1:0]            mem_addr_q;
  logic                                mem_rd_en_q;
  logic [bfbx_pkg::RF_AW-1:0]          ld_dst_q;

  logic                                accept;
  logic                                idle_load;

  logic [bfbx_pkg::DATA_W-1:0]         src;
  logic                                is_shift;
  logic                                is_branch;
  logic                                is_load;
  logic                                is_io;
  logic [7:0]                          io_mask;

  bfbx_exec_if #(.PC_W(PC_W)) ex ();

  ////////////////////////////////////////////////////////////////////////////
  // Issue

  assign op_ready  = (state_q == bfbx_pkg::ST_EXEC);
  assign accept    = ce && op_valid && op_ready;
  // External preloads only when no instruction is taken
  assign idle_load = ce && op_ready && !op_valid;

  // Shift source is read here and written back on the same edge
  assign src       = rf_q[op_reg];

  assign is_shift  = (op_code == bfbx_pkg::OP_SHL) || (op_code == bfbx_pkg::OP_SHR) ||
                     (op_code == bfbx_pkg::OP_ROTL) || (op_code == bfbx_pkg::OP_ROTR) ||
                     (op_code == bfbx_pkg::OP_SHR_ARITH);
  assign is_branch = (op_code == bfbx_pkg::OP_BR_T_CLR) || (op_code == bfbx_pkg::OP_BR_V_SET) ||
                     (op_code == bfbx_pkg::OP_BR_V_CLR) || (op_code == bfbx_pkg::OP_BR_I_SET) ||
                     (op_code == bfbx_pkg::OP_BR_I_CLR);
  assign is_load   = (op_code == bfbx_pkg::OP_LD_X) || (op_code == bfbx_pkg::OP_LD_X_INC) ||
                     (op_code == bfbx_pkg::OP_LD_X_DEC);
  assign is_io     = (op_code == bfbx_pkg::OP_SET_IO_BIT) ||
                     (op_code == bfbx_pkg::OP_CLR_IO_BIT);

  assign ex.op      = op_code;
  assign ex.operand = src;
  assign ex.status_register    = status_register_q;
  assign ex.pc      = pc_q;
  assign ex.k       = op_k;

  bfbx_shift u_shift (
    .bus (ex)
  );

  bfbx_branch u_branch (
    .bus (ex)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Only the two-cycle operations leave EXEC, each for one cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      bfbx_pkg::ST_EXEC: begin
        if (accept) begin
          if (is_branch && ex.taken) begin
            state_d = bfbx_pkg::ST_BR2;
          end else if (is_io) begin
            state_d = bfbx_pkg::ST_IO2;
          end else if (is_load) begin
            state_d = bfbx_pkg::ST_LD2;
          end
        end
      end
      default: begin
        state_d = bfbx_pkg::ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= bfbx_pkg::ST_EXEC;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter

  // Preloads yield to instructions, so a test cannot race the core
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pc_q <= PC_W'(bfbx_pkg::PC_RST);
    end else if (accept) begin
      if (is_branch && ex.taken) begin
        pc_q <= ex.target;
      end else begin
        pc_q <= pc_q + PC_W'(1);
      end
    end else if (idle_load && pc_load_en) begin
      pc_q <= pc_load_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status register

  // Shifts own Z, C, N and V; the flag ops own one bit each
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      status_register_q <= bfbx_pkg::STATUS_REGISTER_RST;
    end else if (accept) begin
      if (is_shift) begin
        status_register_q <= ex.sh_status_register;
      end else if (op_code == bfbx_pkg::OP_FLAG_SET) begin
        status_register_q[op_bit] <= 1'b1;
      end else if (op_code == bfbx_pkg::OP_FLAG_CLR) begin
        status_register_q[op_bit] <= 1'b0;
      end else if (op_code == bfbx_pkg::OP_STORE_T) begin
        status_register_q[bfbx_pkg::SR_T] <= src[op_bit];
      end
    end else if (idle_load && status_register_load_en) begin
      status_register_q <= status_register_load_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  // No reset on the array: it is storage, not control
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      if (state_q == bfbx_pkg::ST_LD2) begin
        rf_q[ld_dst_q] <= mem_rd_data;
      end else if (accept && is_shift) begin
        rf_q[op_reg] <= ex.sh_res;
      end else if (accept && op_code == bfbx_pkg::OP_LOAD_T) begin
        rf_q[op_reg][op_bit] <= status_register_q[bfbx_pkg::SR_T];
      end else if (idle_load && rf_wr_en) begin
        rf_q[rf_wr_addr] <= rf_wr_data;
      end
    end
  end

  // Observe port is registered, so it never races a write
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rf_rd_data_q <= 8'h00;
    end else if (ce) begin
      rf_rd_data_q <= rf_q[rf_rd_addr];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // X pointer and data memory read

  // Pointer arithmetic wraps at the ends of the data space
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      x_q <= bfbx_pkg::X_RST;
    end else if (accept && op_code == bfbx_pkg::OP_LD_X_INC) begin
      x_q <= x_q + 16'h0001;
    end else if (accept && op_code == bfbx_pkg::OP_LD_X_DEC) begin
      x_q <= x_q - 16'h0001;
    end else if (idle_load && x_load_en) begin
      x_q <= x_load_val;
    end
  end

  // Pre-decrement addresses the new X value, the others the old one
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mem_addr_q  <= 16'h0000;
      mem_rd_en_q <= 1'b0;
      ld_dst_q    <= 5'h00;
    end else if (ce) begin
      mem_rd_en_q <= accept && is_load;
      if (accept && is_load) begin
        ld_dst_q <= op_reg;
        if (op_code == bfbx_pkg::OP_LD_X_DEC) begin
          mem_addr_q <= x_q - 16'h0001;
        end else begin
          mem_addr_q <= x_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // I/O bit set and clear

  // Read in the second cycle, write strobe and data follow in the third
  assign io_mask = 8'h01 << io_bit_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      io_addr_q    <= 6'h00;
      io_rd_en_q   <= 1'b0;
      io_bit_q     <= 3'h0;
      io_set_q     <= 1'b0;
    end else if (ce) begin
      // Low ce stretches this strobe; the I/O side must not count it
      io_rd_en_q <= accept && is_io;
      if (accept && is_io) begin
        io_addr_q <= op_io;
        io_bit_q  <= op_bit;
        io_set_q  <= (op_code == bfbx_pkg::OP_SET_IO_BIT);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      io_wr_en_q   <= 1'b0;
      io_wr_data_q <= 8'h00;
    end else if (ce) begin
      io_wr_en_q <= (state_q == bfbx_pkg::ST_IO2);
      if (state_q == bfbx_pkg::ST_IO2) begin
        if (io_set_q) begin
          io_wr_data_q <= io_rd_data | io_mask;
        end else begin
          io_wr_data_q <= io_rd_data & ~io_mask;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign pc         = pc_q;
  assign status     = status_register_q;
  assign x_ptr      = x_q;

  assign io_addr    = io_addr_q;
  assign io_rd_en   = io_rd_en_q;
  assign io_wr_en   = io_wr_en_q;
  assign io_wr_data = io_wr_data_q;

  assign mem_addr   = mem_addr_q;
  assign mem_rd_en  = mem_rd_en_q;
  assign rf_rd_data = rf_rd_data_q;

endmodule

`default_nettype wire

// ==== core/bfbx_pkg.sv ====
// Shared constants and types for the bit, flag and branch execution unit
`default_nettype none

package bfbx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int DATA_W   = 8;
  localparam int PC_W     = 16;
  localparam int X_W      = 16;
  localparam int K_W      = 7;
  localparam int IO_AW    = 6;
  localparam int RF_AW    = 5;
  localparam int RF_DEPTH = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Status register bit positions
  localparam logic [2:0] SR_C = 3'h0;
  localparam logic [2:0] SR_Z = 3'h1;
  localparam logic [2:0] SR_N = 3'h2;
  localparam logic [2:0] SR_V = 3'h3;
  localparam logic [2:0] SR_S = 3'h4;
  localparam logic [2:0] SR_H = 3'h5;
  localparam logic [2:0] SR_T = 3'h6;
  localparam logic [2:0] SR_I = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0]  STATUS_REGISTER_RST = 8'h00;
  localparam logic [15:0] PC_RST   = 16'h0000;
  localparam logic [15:0] X_RST    = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Operations and sequencer states
  typedef enum logic [4:0] {
    OP_NOP         = 5'h00,
    OP_BR_T_CLR    = 5'h01,
    OP_BR_V_SET    = 5'h02,
    OP_BR_V_CLR    = 5'h03,
    OP_BR_I_SET    = 5'h04,
    OP_BR_I_CLR    = 5'h05,
    OP_SET_IO_BIT  = 5'h06,
    OP_CLR_IO_BIT  = 5'h07,
    OP_SHL         = 5'h08,
    OP_SHR         = 5'h09,
    OP_ROTL        = 5'h0a,
    OP_ROTR        = 5'h0b,
    OP_SHR_ARITH   = 5'h0c,
    OP_FLAG_SET    = 5'h0d,
    OP_FLAG_CLR    = 5'h0e,
    OP_STORE_T     = 5'h0f,
    OP_LOAD_T      = 5'h10,
    OP_LD_X        = 5'h11,
    OP_LD_X_INC    = 5'h12,
    OP_LD_X_DEC    = 5'h13
  } bfbx_op_t;

  typedef enum logic [1:0] {
    ST_EXEC = 2'h0,
    ST_BR2  = 2'h1,
    ST_IO2  = 2'h3,
    ST_LD2  = 2'h2
  } bfbx_state_t;

endpackage

`default_nettype wire

// ==== core/bfbx_exec_if.sv ====
// Carrier between the sequencer and its shifter and branch units
`default_nettype none

interface bfbx_exec_if #(
  parameter int PC_W = 16
);
  bfbx_pkg::bfbx_op_t               op;
  logic [bfbx_pkg::DATA_W-1:0]      operand;
  logic [7:0]                       status_register;
  logic [PC_W-1:0]                  pc;
  logic [bfbx_pkg::K_W-1:0]         k;
  logic [bfbx_pkg::DATA_W-1:0]      sh_res;
  logic [7:0]                       sh_status_register;
  logic                             taken;
  logic [PC_W-1:0]                  target;

  modport core   (output op, operand, status_register, pc, k, input sh_res, sh_status_register, taken, target);
  modport shift  (input op, operand, status_register, output sh_res, sh_status_register);
  modport branch (input op, status_register, pc, k, output taken, target);
endinterface

`default_nettype wire

// ==== core/bfbx_shift.sv ====
// Shift and rotate datapath with flag results
`default_nettype none

module bfbx_shift (
  bfbx_exec_if.shift bus // Operand in, result and flags out
);
  logic [7:0] res;
  logic       c;

  always_comb begin
    res = bus.operand;
    c   = bus.status_register[bfbx_pkg::SR_C];
    case (bus.op)
      bfbx_pkg::OP_SHL: begin
        res = {bus.operand[6:0], 1'b0};
        c   = bus.operand[7];
      end
      bfbx_pkg::OP_SHR: begin
        res = {1'b0, bus.operand[7:1]};
        c   = bus.operand[0];
      end
      bfbx_pkg::OP_ROTL: begin
        res = {bus.operand[6:0], bus.status_register[bfbx_pkg::SR_C]};
        c   = bus.operand[7];
      end
      bfbx_pkg::OP_ROTR: begin
        res = {bus.status_register[bfbx_pkg::SR_C], bus.operand[7:1]};
        c   = bus.operand[0];
      end
      bfbx_pkg::OP_SHR_ARITH: begin
        res = {bus.operand[7], bus.operand[7:1]};
        c   = bus.operand[0];
      end
      default: begin
        res = bus.operand;
      end
    endcase
  end

  // Only Z, C, N, V move; S and H are left alone
  always_comb begin
    bus.sh_res                   = res;
    bus.sh_status_register                  = bus.status_register;
    bus.sh_status_register[bfbx_pkg::SR_C]  = c;
    bus.sh_status_register[bfbx_pkg::SR_Z]  = (res == 8'h00);
    bus.sh_status_register[bfbx_pkg::SR_N]  = res[7];
    bus.sh_status_register[bfbx_pkg::SR_V]  = res[7] ^ c;
  end
endmodule

`default_nettype wire

// ==== core/bfbx_branch.sv ====
// Branch condition and relative target
`default_nettype none

module bfbx_branch (
  bfbx_exec_if.branch bus // Flags and offset in, decision out
);
  localparam int W = $bits(bus.pc);

  always_comb begin
    case (bus.op)
      bfbx_pkg::OP_BR_T_CLR: bus.taken = !bus.status_register[bfbx_pkg::SR_T];
      bfbx_pkg::OP_BR_V_SET: bus.taken = bus.status_register[bfbx_pkg::SR_V];
      bfbx_pkg::OP_BR_V_CLR: bus.taken = !bus.status_register[bfbx_pkg::SR_V];
      bfbx_pkg::OP_BR_I_SET: bus.taken = bus.status_register[bfbx_pkg::SR_I];
      bfbx_pkg::OP_BR_I_CLR: bus.taken = !bus.status_register[bfbx_pkg::SR_I];
      default:               bus.taken = 1'b0;
    endcase
  end

  // Offset is signed; wraps modulo the counter width
  assign bus.target = bus.pc + W'(signed'(bus.k)) + W'(1);
endmodule

`default_nettype wire

// ==== test/bfbx_core_assertions.sv ====
// Concurrent port checks for the bit, flag and branch execution unit
`default_nettype none

module bfbx_core_assertions #(
  parameter int PC_W = 16
) (
  input wire logic                clk_sys,    // Clock
  input wire logic                rst_b,      // Reset, active low
  input wire logic                ce,         // Clock enable
  input wire logic                op_valid,   // Offered
  input wire logic                op_ready,   // Ready
  input wire bfbx_pkg::bfbx_op_t  op_code,    // Operation
  input wire logic [2:0]          op_bit,     // Bit select
  input wire logic [6:0]          op_k,       // Offset
  input wire logic [PC_W-1:0]     pc,         // Program counter
  input wire logic [7:0]          status,     // Flags
  input wire logic [15:0]         x_ptr,      // X pointer
  input wire logic                io_rd_en,   // I/O read
  input wire logic [7:0]          io_rd_data, // I/O read data
  input wire logic                io_wr_en,   // I/O write
  input wire logic [7:0]          io_wr_data, // I/O write data
  input wire logic [15:0]         mem_addr,   // Memory address
  input wire logic                mem_rd_en   // Memory read
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////
  // Two-cycle checks assume ce stays high, as the bench keeps it
  logic            acc;
  logic [PC_W-1:0] k_ext;
  assign acc   = op_valid && op_ready && ce;
  assign k_ext = {{(PC_W-7){op_k[6]}}, op_k};

  ////////////////////////////////////////////////////////////////////////////
  property p_shift_keep;
    acc && op_code inside {bfbx_pkg::OP_SHL, bfbx_pkg::OP_SHR, bfbx_pkg::OP_ROTL, bfbx_pkg::OP_ROTR,
      bfbx_pkg::OP_SHR_ARITH} |=> status[7:4] == $past(status[7:4]);
  endproperty
  a_shift_keep: assert property (p_shift_keep) else $error("shift touched I T H S");
  property p_br_untaken;
    acc && op_code == bfbx_pkg::OP_BR_T_CLR && status[6] |=> op_ready && pc == $past(pc) + 1'b1;
  endproperty
  a_br_untaken: assert property (p_br_untaken) else $error("untaken branch wrong");
  property p_br_taken;
    acc && op_code == bfbx_pkg::OP_BR_V_SET && status[3] |=> !op_ready && pc == $past(pc) + $past(k_ext) + 1'b1;
  endproperty
  a_br_taken: assert property (p_br_taken) else $error("taken branch wrong");
  property p_br_irq;
    acc && op_code == bfbx_pkg::OP_BR_I_CLR && status[7] |=> pc == $past(pc) + 1'b1 && $stable(status);
  endproperty
  a_br_irq: assert property (p_br_irq) else $error("irq branch wrong");
  property p_io_set;
    acc && op_code == bfbx_pkg::OP_SET_IO_BIT |=> io_rd_en ##1
      io_wr_en && io_wr_data == ($past(io_rd_data) | (8'h01 << $past(op_bit, 2)));
  endproperty
  a_io_set: assert property (p_io_set) else $error("io set wrong");
  property p_flag_set;
    acc && op_code == bfbx_pkg::OP_FLAG_SET |=> status == ($past(status) | (8'h01 << $past(op_bit)));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag set wrong");
  property p_flag_clr;
    acc && op_code == bfbx_pkg::OP_FLAG_CLR |=> status == ($past(status) & ~(8'h01 << $past(op_bit)));
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag clear wrong");
  property p_store_t;
    acc && op_code == bfbx_pkg::OP_STORE_T |=> (status & 8'hbf) == ($past(status) & 8'hbf);
  endproperty
  a_store_t: assert property (p_store_t) else $error("bit store touched flags");
  property p_ld_inc;
    acc && op_code == bfbx_pkg::OP_LD_X_INC |=> mem_rd_en && mem_addr == $past(x_ptr) && x_ptr == $past(x_ptr) + 16'h1;
  endproperty
  a_ld_inc: assert property (p_ld_inc) else $error("post-increment load wrong");
  property p_ld_dec;
    acc && op_code == bfbx_pkg::OP_LD_X_DEC |=> mem_rd_en && mem_addr == x_ptr && x_ptr == $past(x_ptr) - 16'h1;
  endproperty
  a_ld_dec: assert property (p_ld_dec) else $error("pre-decrement load wrong");

  c_taken: cover property (acc && op_code == bfbx_pkg::OP_BR_V_SET && status[3]);
  c_io: cover property (acc && op_code == bfbx_pkg::OP_SET_IO_BIT);
  c_ld: cover property (acc && op_code == bfbx_pkg::OP_LD_X_DEC);
endmodule

bind bfbx_core bfbx_core_assertions #(.PC_W(PC_W)) u_chk (.*);

`default_nettype wire

// ==== test/test_bfbx_core.sv ====
// Self-checking bench for the bit, flag and branch execution unit
`default_nettype none

`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module test_bfbx_core;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [2:0]  sel;
    logic [15:0] exp;
  } bfbx_note_t;

  logic               clk_sys, rst_b, ce, op_valid, op_ready, io_rd_en, io_wr_en, mem_rd_en, tk, frz;
  logic               rf_wr_en, x_load_en, status_register_load_en, pc_load_en;
  bfbx_pkg::bfbx_op_t op_code, op;
  logic [4:0]         op_reg, rf_wr_addr, rf_rd_addr;
  logic [2:0]         op_bit;
  logic [5:0]         op_io, io_addr;
  logic [6:0]         op_k;
  logic [7:0]         status, io_rd_data, io_wr_data, mem_rd_data, rf_wr_data, rf_rd_data, status_register_load_val, d, sr;
  logic [15:0]        pc, x_ptr, mem_addr, x_load_val, pc_load_val, epc, rv, e;
  logic [31:0]        seed;
  int                 bad_count, total_checks, cyc, last_cyc;
  bfbx_note_t         q[$];
  bfbx_note_t         nt;

  bfbx_core DUT (.*);

  always #50 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  function automatic logic [15:0] shx(input bfbx_pkg::bfbx_op_t o, input logic [7:0] v, input logic [7:0] s);
    logic [7:0] res;
    logic       c;
    case (o)
      bfbx_pkg::OP_SHL:  {c, res} = {v, 1'b0};
      bfbx_pkg::OP_SHR:  {res, c} = {1'b0, v};
      bfbx_pkg::OP_ROTL: {c, res} = {v, s[0]};
      bfbx_pkg::OP_ROTR: {res, c} = {s[0], v};
      default:           {res, c} = {v[7], v};
    endcase
    s[0] = c;
    s[1] = res == 8'h00;
    s[2] = res[7];
    s[3] = res[7] ^ c;
    return {s, res};
  endfunction

  function automatic logic [15:0] obs(input logic [2:0] s);
    case (s)
      3'h0: return pc;
      3'h1: return {8'h00, status};
      3'h2: return x_ptr;
      3'h3: return {8'h00, rf_rd_data};
      3'h4: return {7'h00, io_wr_en, io_wr_data};
      3'h5: return {10'h000, io_addr};
      default: return 16'(last_cyc);
    endcase
  endfunction

  task automatic note(input logic [2:0] s, input logic [15:0] x);
    q.push_back({s, x});
  endtask

  // Preloads land only while no instruction is offered
  task automatic pre(input logic [4:0] r, input logic [7:0] v, input logic [7:0] s, input logic [15:0] x);
    @(negedge clk_sys);
    {rf_wr_en, status_register_load_en, x_load_en, pc_load_en} = 4'hf;
    {rf_wr_addr, rf_wr_data, status_register_load_val, x_load_val} = {r, v, s, x};
    pc_load_val = rnd();
    epc = pc_load_val;
    @(negedge clk_sys);
    {rf_wr_en, status_register_load_en, x_load_en, pc_load_en} = 4'h0;
  endtask

  task automatic run(input bfbx_pkg::bfbx_op_t o, input logic [4:0] r, input logic [2:0] b, input logic [6:0] k);
    @(negedge clk_sys);
    {op_valid, op_reg, op_bit, op_io, op_k} = {1'b1, r, b, rv[13:8], k};
    op_code = o;
    // Offered while ce is low: must not be taken until ce returns
    if (frz) begin
      ce = 1'b0;
      @(negedge clk_sys);
      ce = 1'b1;
    end
    @(negedge clk_sys);
    op_valid = 1'b0;
    last_cyc = 1;
    while (op_ready !== 1'b1 && last_cyc < 8) begin
      @(negedge clk_sys);
      last_cyc++;
    end
  endtask

  task automatic rfchk(input logic [4:0] r, input logic [7:0] x);
    rf_rd_addr = r;
    @(negedge clk_sys);
    note(3'h3, {8'h00, x});
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Values seen at a rising edge are those that stood during the cycle noted
  always @(posedge clk_sys) begin
    cyc++;
    while (q.size() > 0) begin
      nt = q.pop_front();
      `CHK(obs(nt.sel), nt.exp)
    end
    if (cyc == 5000) begin
      bad_count++;
      print_verdict();
    end
  end

  initial begin
    {clk_sys, rst_b, ce, op_valid, rf_wr_en, x_load_en, status_register_load_en, pc_load_en} = 8'h20;
    op_code = bfbx_pkg::OP_NOP;
    {op_reg, op_bit, op_io, op_k, rf_wr_addr, rf_rd_addr} = '0;
    {io_rd_data, mem_rd_data, rf_wr_data, status_register_load_val, x_load_val, pc_load_val} = '0;
    {bad_count, total_checks, cyc, last_cyc} = '0;
    seed = 32'h21;
    repeat (3) @(negedge clk_sys);
    rst_b = 1'b1;
    note(3'h0, 16'h0000);
    note(3'h1, 16'h0000);
    note(3'h2, 16'h0000);
    note(3'h3, 16'h0000);
    for (int i = 0; i < 40; i++) begin
      rv = rnd();
      op = bfbx_pkg::bfbx_op_t'(5'(8 + i % 5));
      pre(5'(i), rv[7:0], rv[15:8], 16'h0000);
      frz = i[1];
      run(op, 5'(i), 3'h0, 7'h00);
      e = shx(op, rv[7:0], rv[15:8]);
      epc++;
      note(3'h1, {8'h00, e[15:8]});
      note(3'h0, epc);
      note(3'h6, 16'h0001);
      rfchk(5'(i), e[7:0]);
    end
    frz = 1'b0;
    for (int i = 0; i < 16; i++) begin
      rv = rnd();
      pre(5'h00, 8'h00, rv[7:0], 16'h0000);
      run(i[0] ? bfbx_pkg::OP_FLAG_SET : bfbx_pkg::OP_FLAG_CLR, 5'h00, 3'(i / 2), 7'h00);
      sr = rv[7:0];
      sr[i / 2] = i[0];
      note(3'h1, {8'h00, sr});
    end
    for (int i = 0; i < 8; i++) begin
      rv = rnd();
      pre(5'h03, rv[7:0], rv[15:8], 16'h0000);
      run(bfbx_pkg::OP_STORE_T, 5'h03, 3'(i), 7'h00);
      {sr, d} = rv;
      sr[6] = rv[i];
      d[7 - i] = rv[i];
      note(3'h1, {8'h00, sr});
      run(bfbx_pkg::OP_LOAD_T, 5'h03, 3'(7 - i), 7'h00);
      note(3'h1, {8'h00, sr});
      rfchk(5'h03, d);
    end
    for (int i = 0; i < 20; i++) begin
      rv = rnd();
      op = bfbx_pkg::bfbx_op_t'(5'(1 + (i / 2) % 5));
      sr = rv[7:0];
      {sr[7:6], sr[3]} = {3{i[0]}};
      tk = i[0] ^ op[0];
      pre(5'h00, 8'h00, sr, 16'h0000);
      run(op, 5'h00, 3'h0, rv[14:8]);
      epc = epc + 16'h0001 + (tk ? {{9{rv[14]}}, rv[14:8]} : 16'h0000);
      note(3'h0, epc);
      note(3'h1, {8'h00, sr});
      note(3'h6, tk ? 16'h0002 : 16'h0001);
    end
    for (int i = 0; i < 16; i++) begin
      rv = rnd();
      io_rd_data = rv[7:0];
      run(i[0] ? bfbx_pkg::OP_SET_IO_BIT : bfbx_pkg::OP_CLR_IO_BIT, 5'h00, 3'(i / 2), 7'h00);
      d = rv[7:0];
      d[i / 2] = i[0];
      note(3'h4, {8'h01, d});
      note(3'h5, {10'h000, rv[13:8]});
      note(3'h6, 16'h0002);
    end
    for (int i = 0; i < 9; i++) begin
      rv = rnd();
      op = bfbx_pkg::bfbx_op_t'(5'(17 + i % 3));
      pre(5'h00, 8'h00, 8'h00, rv);
      mem_rd_data = rv[15:8];
      run(op, 5'h09, 3'h0, 7'h00);
      e = op == bfbx_pkg::OP_LD_X_INC ? rv + 16'h1 : (op == bfbx_pkg::OP_LD_X_DEC ? rv - 16'h1 : rv);
      note(3'h2, e);
      note(3'h1, 16'h0000);
      note(3'h6, 16'h0002);
      rfchk(5'h09, rv[15:8]);
    end
    @(negedge clk_sys);
    print_verdict();
  end
endmodule

`default_nettype wire
